// File: inc/rpmsc_map.svh
`ifndef RPMSC_MAP_SVH
`define RPMSC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RPMSC_OFF_CTRL   8'h00
`define RPMSC_OFF_CAUSE  8'h04
`define RPMSC_OFF_STATUS 8'h08
`define RPMSC_OFF_MASK   8'h0C
`define RPMSC_OFF_INFO   8'h10

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RPMSC_CTRL_CLKSEL_LO 0
`define RPMSC_CTRL_CLKSEL_HI 1
`define RPMSC_CTRL_DBGSELF   2
`define RPMSC_CTRL_RTIEXT    3
`define RPMSC_CTRL_ADCALT    4
`define RPMSC_CTRL_STOPSELF  5
`define RPMSC_CTRL_IRQEN     6
`define RPMSC_CTRL_SWRST     7
`define RPMSC_CTRL_W         7
`define RPMSC_CTRL_RST       7'h00

// ----------------------------------------------------------------
// Clock source encodings
// ----------------------------------------------------------------
`define RPMSC_SRC_SELF   2'h0
`define RPMSC_SRC_XTAL   2'h1
`define RPMSC_SRC_EXTCLK 2'h2
`define RPMSC_SRC_OSC    2'h3

// ----------------------------------------------------------------
// Reset cause bits
// ----------------------------------------------------------------
`define RPMSC_CAUSE_POR  0
`define RPMSC_CAUSE_PIN  1
`define RPMSC_CAUSE_LVD  2
`define RPMSC_CAUSE_WDOG 3
`define RPMSC_CAUSE_SW   4
`define RPMSC_CAUSE_W    5
`define RPMSC_CAUSE_RST  5'h01

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define RPMSC_EV_DONE    0
`define RPMSC_EV_FAULT   1
`define RPMSC_EV_EXTRST  2
`define RPMSC_EV_IRQ     3
`define RPMSC_EV_W       4
`define RPMSC_EV_RST     4'h0

// ----------------------------------------------------------------
// Timing counts in cycles, and the reset vector address
// ----------------------------------------------------------------
`define RPMSC_DRIVE_CYC   34
`define RPMSC_SAMPLE_CYC  38
`define RPMSC_BIT_CYC     16
`define RPMSC_SPEEDUP_CYC 2
`define RPMSC_RESET_VEC   16'hFFFE

`endif

// File: inc/rpmsc_pkg.sv
package rpmsc_pkg;

  typedef enum logic [1:0] {
    RPMSC_ST_DRIVE,
    RPMSC_ST_WAIT,
    RPMSC_ST_HOLD,
    RPMSC_ST_RUN
  } rpmsc_state_t;

  typedef logic [1:0] rpmsc_clksrc_t;

endpackage

// File: testbench/rpmsc_bench.sv
`timescale 1ns/1ps
`include "rpmsc_map.svh"
module rpmsc_bench
  import rpmsc_pkg::*;
();
  logic core_clk_i, sys_rst_i, reg_we_i, reg_re_i, rst_pin_i, dbg_pin_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [15:0] gen_freq_i, ref_freq_i, vec_addr_o, r;
  logic [1:0] gen_clk_sel_o;
  logic lvd_rst_i, wdog_rst_i, dbg_drive_low_i, dbg_bit_sync_i;
  logic ext_ref_tick_i, irq_pin_i, ms_low, sw_low, rd_d;
  logic rst_pin_o, rst_pin_oe_o, mcu_rst_o, active_bg_mode_o, vec_fetch_o;
  logic dbg_pin_o, dbg_pin_oe_o, dbg_rx_o, dbg_bit_tick_o, int_o;
  logic fixed_freq_select_o, ffclk_en_o, rti_ext_ref_o, adc_alt_ref_o;
  logic stop_self_clk_o, irq_req_o, irq_level_o;
  logic [4:0] cz [5] = '{5'h04, 5'h08, 5'h10, 5'h02, 5'h04};
  logic [3:0] st [5] = '{4'h1, 4'h1, 4'h1, 4'h5, 4'h3};
  logic [31:0] exp_q [$];
  int errors = 0;
  int num_checks = 0;
  int n;

  rpmsc_top i_dut (
    .core_clk_i, .sys_rst_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .rst_pin_i, .rst_pin_o,
    .rst_pin_oe_o, .lvd_rst_i, .wdog_rst_i, .mcu_rst_o, .active_bg_mode_o,
    .vec_fetch_o, .vec_addr_o, .dbg_pin_i, .dbg_pin_o, .dbg_pin_oe_o,
    .dbg_drive_low_i, .dbg_bit_sync_i, .dbg_rx_o, .dbg_bit_tick_o,
    .local_clk_tick_i(ext_ref_tick_i), .ext_ref_tick_i, .gen_freq_i,
    .ref_freq_i,
    .fixed_freq_select_o, .ffclk_en_o, .gen_clk_sel_o, .rti_ext_ref_o,
    .adc_alt_ref_o, .stop_self_clk_o, .irq_pin_i, .irq_req_o,
    .irq_level_o, .int_o
  );
  rpmsc_host i_host (
    .ms_low_i(ms_low), .sw_low_i(sw_low), .rst_oe_i(rst_pin_oe_o),
    .rst_out_i(rst_pin_o), .dbg_oe_i(dbg_pin_oe_o), .dbg_out_i(dbg_pin_o),
    .rst_line_o(rst_pin_i), .dbg_line_o(dbg_pin_i)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    cyc(1);
    reg_we_i <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    cyc(1);
    reg_re_i <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    cyc(2);
    while (mcu_rst_o !== 1'b0 && k < 400) begin
      cyc(1);
      k++;
    end
    chk("run", 32'(mcu_rst_o), 32'h0000_0000);
  endtask
  task automatic tick_gap(output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
    end while (dbg_bit_tick_o !== 1'b1 && c < 100);
  endtask
  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    ext_ref_tick_i <= ~ext_ref_tick_i;
    rd_d <= reg_re_i;
    if (rd_d) begin
      chk("rdata", reg_rdata_o, exp_q.pop_front());
    end
  end
  initial begin
    cyc(6000);
    errors++;
    $display("[ERR] watchdog exp finish got hang");
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3af3_baee));
    sys_rst_i = 1'b1;
    {reg_we_i, reg_re_i, lvd_rst_i, wdog_rst_i, ms_low, sw_low} = '0;
    {dbg_drive_low_i, dbg_bit_sync_i, ext_ref_tick_i, rd_d} = '0;
    {reg_addr_i, reg_wdata_i, gen_freq_i, ref_freq_i} = '0;
    irq_pin_i = 1'b1;
    cyc(12);
    sys_rst_i <= 1'b0;
    wait_run();
    chk("bg", 32'(active_bg_mode_o), 32'h0000_0000);
    chk("clksel", 32'(gen_clk_sel_o), 32'h0000_0000);
    rd(`RPMSC_OFF_CAUSE, 32'h0000_0001);
    rd(`RPMSC_OFF_STATUS, 32'h0000_0001);
    rd(`RPMSC_OFF_STATUS, 32'h0000_0000);
    wr(`RPMSC_OFF_CAUSE, 32'h0000_001F);
    rd(`RPMSC_OFF_CAUSE, 32'h0000_0001);
    rd(8'h14, 32'h0000_0000);
    $display("test power-on done");
    for (int i = 0; i < 4; i++) begin
      d = ($urandom & 32'h0000_0038) | i;
      wr(`RPMSC_OFF_CTRL, d);
      cyc(1);
      chk("sel", 32'(gen_clk_sel_o), d & 32'h0000_0003);
      chk("aux", 32'({stop_self_clk_o, adc_alt_ref_o, rti_ext_ref_o}), d >> 3);
      rd(`RPMSC_OFF_CTRL, d);
    end
    $display("test clock select done");
    for (int i = 0; i < 6; i++) begin
      r = 16'(($urandom & 32'h0000_0FFF) + 1);
      ref_freq_i <= r;
      gen_freq_i <= 16'(4 * r + i - 2);
      cyc(3);
      chk("ffsel", 32'(fixed_freq_select_o), 32'(i > 2));
      n = 0;
      repeat (8) begin
        cyc(1);
        n += ffclk_en_o;
      end
      chk("ffen", 32'(n), (i < 3) ? 32'h0000_0008 : 32'h0000_0002);
      rd(`RPMSC_OFF_INFO, 32'(i > 2));
    end
    $display("test fixed clock done");
    ms_low <= 1'b1;
    cyc(5);
    chk("rx", 32'(dbg_rx_o), 32'h0000_0000);
    ms_low <= 1'b0;
    dbg_drive_low_i <= 1'b1;
    cyc(3);
    chk("line", 32'(dbg_pin_i), 32'h0000_0000);
    dbg_drive_low_i <= 1'b0;
    cyc(5);
    chk("free", 32'(dbg_pin_oe_o), 32'h0000_0000);
    dbg_bit_sync_i <= 1'b1;
    cyc(1);
    dbg_bit_sync_i <= 1'b0;
    tick_gap(n);
    tick_gap(n);
    chk("bit", 32'(n), 32'h0000_0010);
    dbg_bit_sync_i <= 1'b1;
    wr(`RPMSC_OFF_CTRL, 32'h0000_0004);
    dbg_bit_sync_i <= 1'b0;
    tick_gap(n);
    dbg_bit_sync_i <= 1'b1;
    wr(`RPMSC_OFF_CTRL, 32'h0000_0000);
    dbg_bit_sync_i <= 1'b0;
    chk("selfbit", 32'(n > 24), 32'h0000_0001);
    $display("test debug line done");
    wr(`RPMSC_OFF_MASK, 32'h0000_000F);
    wr(`RPMSC_OFF_CTRL, 32'h0000_0040);
    irq_pin_i <= 1'b0;
    cyc(5);
    chk("req", 32'(irq_req_o), 32'h0000_0001);
    chk("int", 32'(int_o), 32'h0000_0001);
    wr(`RPMSC_OFF_MASK, 32'h0000_0007);
    cyc(1);
    chk("masked", 32'(int_o), 32'h0000_0000);
    irq_pin_i <= 1'b1;
    rd(`RPMSC_OFF_STATUS, 32'h0000_0008);
    wr(`RPMSC_OFF_MASK, 32'h0000_000F);
    cyc(1);
    chk("cleared", 32'(int_o), 32'h0000_0000);
    wr(`RPMSC_OFF_CTRL, 32'h0000_0000);
    irq_pin_i <= 1'b0;
    cyc(5);
    chk("off", 32'({irq_req_o, irq_level_o}), 32'h0000_0001);
    rd(`RPMSC_OFF_STATUS, 32'h0000_0000);
    irq_pin_i <= 1'b1;
    $display("test interrupt pin done");
    for (int k = 0; k < 5; k++) begin
      ms_low <= (k == 1);
      if (k == 2) begin
        wr(`RPMSC_OFF_CTRL, 32'h0000_0080);
      end else begin
        lvd_rst_i <= (k == 0 || k == 4);
        wdog_rst_i <= (k == 1);
        sw_low <= (k >= 3);
        cyc(3);
        lvd_rst_i <= 1'b0;
        wdog_rst_i <= 1'b0;
        sw_low <= (k >= 3);
      end
      if (k >= 3) begin
        cyc(90);
        sw_low <= 1'b0;
      end
      wait_run();
      chk("mode", 32'(active_bg_mode_o), 32'(k == 1));
      ms_low <= 1'b0;
      rd(`RPMSC_OFF_CAUSE, 32'(cz[k]));
      rd(`RPMSC_OFF_STATUS, 32'(st[k]));
    end
    $display("test reset causes done");
    summarize();
  end
endmodule

// File: testbench/rpmsc_host.sv
`timescale 1ns/1ps
module rpmsc_host (
  input wire logic ms_low_i,
  input wire logic sw_low_i,
  input wire logic rst_oe_i,
  input wire logic rst_out_i,
  input wire logic dbg_oe_i,
  input wire logic dbg_out_i,
  output logic rst_line_o,
  output logic dbg_line_o
);
  assign rst_line_o = ~sw_low_i & (~rst_oe_i | rst_out_i);
  assign dbg_line_o = ~ms_low_i & (~dbg_oe_i | dbg_out_i);
endmodule

// File: testbench/rpmsc_monitor.sv
`timescale 1ns/1ps
module rpmsc_monitor #(
  parameter int DRIVE_CYC = 34,
  parameter int SAMPLE_CYC = 38,
  parameter int BIT_CYC = 16,
  parameter int FREQ_W = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rst_pin_oe_o,
  input wire logic mcu_rst_o,
  input wire logic active_bg_mode_o,
  input wire logic vec_fetch_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic dbg_pin_i,
  input wire logic dbg_pin_o,
  input wire logic dbg_pin_oe_o,
  input wire logic dbg_drive_low_i,
  input wire logic dbg_bit_sync_i,
  input wire logic dbg_bit_tick_o,
  input wire logic [FREQ_W-1:0] gen_freq_i,
  input wire logic [FREQ_W-1:0] ref_freq_i,
  input wire logic fixed_freq_select_o,
  input wire logic irq_req_o,
  input wire logic irq_level_o
);
  logic [7:0] oe_cnt_r, wait_cnt_r, gap_r;
  logic oe_d_r, gap_ok_r;
  // ----------------------------------------
  // Phase counters
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_cnt_r <= 8'hFF;
      oe_d_r <= 1'b1;
      wait_cnt_r <= 8'h00;
      gap_r <= 8'h00;
      gap_ok_r <= 1'b0;
    end else begin
      oe_d_r <= rst_pin_oe_o;
      if (rst_pin_oe_o && !oe_d_r) begin
        oe_cnt_r <= 8'h01;
      end else if (rst_pin_oe_o && oe_cnt_r != 8'hFF) begin
        oe_cnt_r <= oe_cnt_r + 8'h01;
      end
      wait_cnt_r <= rst_pin_oe_o ? 8'h00 : wait_cnt_r + 8'(mcu_rst_o);
      gap_r <= dbg_bit_tick_o ? 8'h00 : gap_r + 8'h01;
      gap_ok_r <= (gap_ok_r | dbg_bit_tick_o) & ~dbg_bit_sync_i & ~mcu_rst_o;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_drive_len: assert property (
    $fell(rst_pin_oe_o) && oe_cnt_r != 8'hFF |-> oe_cnt_r == DRIVE_CYC)
    else $error("reset drive length wrong");
  a_wait_len: assert property (
    $fell(mcu_rst_o) |-> wait_cnt_r >= SAMPLE_CYC)
    else $error("reset released before sample");
  a_mode_pick: assert property (
    $fell(mcu_rst_o) && $past(dbg_pin_i, 3) == $past(dbg_pin_i, 6)
    |-> active_bg_mode_o == !$past(dbg_pin_i, 3))
    else $error("mode not taken from pin");
  a_vec_start: assert property (
    $fell(mcu_rst_o) |-> vec_fetch_o == !active_bg_mode_o ##1 !vec_fetch_o)
    else $error("vector fetch pulse wrong");
  a_vec_addr: assert property (
    vec_fetch_o |-> vec_addr_o == 16'hFFFE && !mcu_rst_o)
    else $error("vector address wrong");
  a_fixed_sel: assert property (
    !$past(sys_rst_i)
    |-> fixed_freq_select_o == ($past(gen_freq_i) > 4 * $past(ref_freq_i)))
    else $error("fixed freq select wrong");
  a_dbg_low: assert property (
    !mcu_rst_o && dbg_drive_low_i ##1 !mcu_rst_o
    |-> dbg_pin_oe_o && !dbg_pin_o)
    else $error("debug line not driven low");
  a_speed_up: assert property (
    !mcu_rst_o && $fell(dbg_drive_low_i)
    |=> (dbg_pin_oe_o && dbg_pin_o)[*2] ##1 !dbg_pin_oe_o)
    else $error("speedup pulse wrong");
  a_rst_quiet: assert property (
    mcu_rst_o |-> !dbg_pin_oe_o)
    else $error("debug line driven in reset");
  a_bit_time: assert property (
    dbg_bit_tick_o && gap_ok_r |-> gap_r == BIT_CYC - 1)
    else $error("bit time length wrong");
  a_rd_idle: assert property (
    !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
  a_irq_level: assert property (
    irq_req_o |-> !irq_level_o)
    else $error("request without low level");
endmodule
bind rpmsc_top rpmsc_monitor #(
  .DRIVE_CYC(DRIVE_CYC), .SAMPLE_CYC(SAMPLE_CYC),
  .BIT_CYC(BIT_CYC), .FREQ_W(FREQ_W)
) i_mon (
  .core_clk_i, .sys_rst_i, .reg_re_i, .reg_rdata_o, .rst_pin_oe_o,
  .mcu_rst_o, .active_bg_mode_o, .vec_fetch_o, .vec_addr_o, .dbg_pin_i,
  .dbg_pin_o, .dbg_pin_oe_o, .dbg_drive_low_i, .dbg_bit_sync_i,
  .dbg_bit_tick_o, .gen_freq_i, .ref_freq_i, .fixed_freq_select_o,
  .irq_req_o, .irq_level_o
);

// File: verilog/rpmsc_sync.sv
`timescale 1ns/1ps

module rpmsc_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        meta_r[i] <= RST_VAL;
        sync_r[i] <= RST_VAL;
      end else if (ce_i) begin
        meta_r[i] <= d_i[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign q_o = sync_r;

endmodule

// File: verilog/rpmsc_top.sv
// How it works
// - Fixed-freq clock is ext ref / 2 when gen clock exceeds 4x ref.
// - Control field picks crystal, external clock or oscillator as source.
// - Debug bit clock may come from the local self clock.
// - Ext ref can feed the RTI and the converter alternate clock.
// - Clock source starts at self clock; self clock usable for stop recovery.
// - Any reset drives pin low 34 cycles, samples it 38 later.
// - Internal reset expects the delayed pin sample to read high.
// - Each reset's cause is recorded in the cause register.
// - Mode pin sampled at reset release; low selects background mode.
// - Pin is mode select in reset, debug line afterwards.
// - One debug bit time is 16 debug clock cycles.
// - Open-drain debug line gets short driven-high speedup pulses.
// - Interrupt pin gives the request and the branch test level.
// - Interrupt pin does nothing while its function is disabled.
// - Normal run starts fetching from the reset vector pair.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "rpmsc_map.svh"

module rpmsc_top
  import rpmsc_pkg::*;
#(
  parameter int DRIVE_CYC = `RPMSC_DRIVE_CYC,
  parameter int SAMPLE_CYC = `RPMSC_SAMPLE_CYC,
  parameter int BIT_CYC = `RPMSC_BIT_CYC,
  parameter int SPEEDUP_CYC = `RPMSC_SPEEDUP_CYC,
  parameter int FREQ_W = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  input wire logic lvd_rst_i,
  input wire logic wdog_rst_i,
  output logic mcu_rst_o,
  output logic active_bg_mode_o,
  output logic vec_fetch_o,
  output logic [15:0] vec_addr_o,
  input wire logic dbg_pin_i,
  output logic dbg_pin_o,
  output logic dbg_pin_oe_o,
  input wire logic dbg_drive_low_i,
  input wire logic dbg_bit_sync_i,
  output logic dbg_rx_o,
  output logic dbg_bit_tick_o,
  input wire logic local_clk_tick_i,
  input wire logic ext_ref_tick_i,
  input wire logic [FREQ_W-1:0] gen_freq_i,
  input wire logic [FREQ_W-1:0] ref_freq_i,
  output logic fixed_freq_select_o,
  output logic ffclk_en_o,
  output logic [1:0] gen_clk_sel_o,
  output logic rti_ext_ref_o,
  output logic adc_alt_ref_o,
  output logic stop_self_clk_o,
  input wire logic irq_pin_i,
  output logic irq_req_o,
  output logic irq_level_o,
  output logic int_o
);

  localparam int CMAX = (DRIVE_CYC > SAMPLE_CYC) ? DRIVE_CYC : SAMPLE_CYC;
  localparam int CW = $clog2(CMAX + 1);
  localparam int BW = $clog2(BIT_CYC + 1);
  localparam int SW = $clog2(SPEEDUP_CYC + 1);

  if (DRIVE_CYC < 1 || SAMPLE_CYC < 4 || BIT_CYC < 2 ||
      SPEEDUP_CYC < 1 || FREQ_W < 1) begin : g_bad_param
    $error("rpmsc_top: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s;
  logic dbg_s;
  logic irq_s;

  rpmsc_sync #(.W(3), .RST_VAL(1'b1)) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i({irq_pin_i, dbg_pin_i, rst_pin_i}),
    .q_o({irq_s, dbg_s, rst_s})
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`RPMSC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`RPMSC_EV_W-1:0] mask_r, mask_nxt;
  logic [`RPMSC_EV_W-1:0] status_r, status_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sw_req_r, sw_req_nxt;
  logic [`RPMSC_CAUSE_W-1:0] cause_r, cause_nxt;
  logic [`RPMSC_EV_W-1:0] ev;
  logic ev_irq;
  logic ffs_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    sw_req_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    status_nxt = status_r;
    if (reg_we_i) begin
      case (reg_addr_i)
        `RPMSC_OFF_CTRL: begin
          ctrl_nxt = reg_wdata_i[`RPMSC_CTRL_W-1:0];
          sw_req_nxt = reg_wdata_i[`RPMSC_CTRL_SWRST];
        end
        `RPMSC_OFF_MASK: mask_nxt = reg_wdata_i[`RPMSC_EV_W-1:0];
        default: ;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        `RPMSC_OFF_CTRL: rdata_nxt[`RPMSC_CTRL_W-1:0] = ctrl_r;
        // Cause readback
        `RPMSC_OFF_CAUSE: rdata_nxt[`RPMSC_CAUSE_W-1:0] = cause_r;
        `RPMSC_OFF_STATUS: begin
          rdata_nxt[`RPMSC_EV_W-1:0] = status_r;
          status_nxt = '0;
        end
        `RPMSC_OFF_MASK: rdata_nxt[`RPMSC_EV_W-1:0] = mask_r;
        `RPMSC_OFF_INFO: rdata_nxt[1:0] = {active_bg_mode_o, ffs_r};
        default: ;
      endcase
    end
    // New events win over a read clear
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= `RPMSC_CTRL_RST;
      mask_r <= `RPMSC_EV_RST;
      status_r <= `RPMSC_EV_RST;
      rdata_r <= 32'h0000_0000;
      sw_req_r <= 1'b0;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      sw_req_r <= sw_req_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign int_o = |(status_r & mask_r);
  assign gen_clk_sel_o = ctrl_r[`RPMSC_CTRL_CLKSEL_HI:`RPMSC_CTRL_CLKSEL_LO];
  assign rti_ext_ref_o = ctrl_r[`RPMSC_CTRL_RTIEXT];
  assign adc_alt_ref_o = ctrl_r[`RPMSC_CTRL_ADCALT];
  assign stop_self_clk_o = ctrl_r[`RPMSC_CTRL_STOPSELF];

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  rpmsc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic mode_r, mode_nxt;
  logic mcu_rst_r, rst_oe_r, fetch_r;
  logic int_src;

  assign int_src = cause_r[`RPMSC_CAUSE_LVD] | cause_r[`RPMSC_CAUSE_WDOG] |
                   cause_r[`RPMSC_CAUSE_SW];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cause_nxt = cause_r;
    mode_nxt = mode_r;
    ev = '0;
    ev[`RPMSC_EV_IRQ] = ev_irq;
    case (state_r)
      RPMSC_ST_DRIVE: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r == CW'(DRIVE_CYC - 1)) begin
          state_nxt = RPMSC_ST_WAIT;
          cnt_nxt = '0;
        end
      end
      RPMSC_ST_WAIT: begin
        cnt_nxt = cnt_r + CW'(1);
        if (cnt_r == CW'(SAMPLE_CYC - 1)) begin
          cnt_nxt = '0;
          if (rst_s) begin
            state_nxt = RPMSC_ST_RUN;
          end else begin
            state_nxt = RPMSC_ST_HOLD;
            if (int_src) begin
              ev[`RPMSC_EV_FAULT] = 1'b1;
            end else begin
              cause_nxt[`RPMSC_CAUSE_PIN] = 1'b1;
            end
          end
        end
      end
      RPMSC_ST_HOLD: begin
        if (rst_s) begin
          state_nxt = RPMSC_ST_RUN;
        end
      end
      RPMSC_ST_RUN: begin
        if (lvd_rst_i) begin
          state_nxt = RPMSC_ST_DRIVE;
          cause_nxt = `RPMSC_CAUSE_W'(1) << `RPMSC_CAUSE_LVD;
        end else if (wdog_rst_i) begin
          state_nxt = RPMSC_ST_DRIVE;
          cause_nxt = `RPMSC_CAUSE_W'(1) << `RPMSC_CAUSE_WDOG;
        end else if (sw_req_r) begin
          state_nxt = RPMSC_ST_DRIVE;
          cause_nxt = `RPMSC_CAUSE_W'(1) << `RPMSC_CAUSE_SW;
        end else if (!rst_s) begin
          state_nxt = RPMSC_ST_DRIVE;
          cause_nxt = `RPMSC_CAUSE_W'(1) << `RPMSC_CAUSE_PIN;
          ev[`RPMSC_EV_EXTRST] = 1'b1;
        end
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = RPMSC_ST_DRIVE;
        cnt_nxt = '0;
      end
    endcase
    if (state_r != RPMSC_ST_RUN && state_nxt == RPMSC_ST_RUN) begin
      mode_nxt = !dbg_s;
      ev[`RPMSC_EV_DONE] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= RPMSC_ST_DRIVE;
      cnt_r <= '0;
      cause_r <= `RPMSC_CAUSE_RST;
      mode_r <= 1'b0;
      mcu_rst_r <= 1'b1;
      rst_oe_r <= 1'b1;
      fetch_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cause_r <= cause_nxt;
      mode_r <= mode_nxt;
      mcu_rst_r <= state_nxt != RPMSC_ST_RUN;
      rst_oe_r <= state_nxt == RPMSC_ST_DRIVE;
      fetch_r <= ev[`RPMSC_EV_DONE] & dbg_s;
    end
  end

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = rst_oe_r;
  assign mcu_rst_o = mcu_rst_r;
  assign active_bg_mode_o = mode_r;
  assign vec_fetch_o = fetch_r;
  assign vec_addr_o = `RPMSC_RESET_VEC;

  // ----------------------------------------------------------------
  // Debug line
  // ----------------------------------------------------------------
  logic drv_prev_r, drv_prev_nxt;
  logic [SW-1:0] spd_r, spd_nxt;
  logic [BW-1:0] bit_r, bit_nxt;
  logic tick_r, tick_nxt;
  logic dbg_oe_r, dbg_oe_nxt;
  logic dbg_o_r, dbg_o_nxt;
  logic dbg_rx_r, dbg_rx_nxt;
  logic dbg_clk_en;

  assign dbg_clk_en = ctrl_r[`RPMSC_CTRL_DBGSELF] ? local_clk_tick_i : 1'b1;

  always_comb begin
    drv_prev_nxt = dbg_drive_low_i;
    spd_nxt = spd_r;
    bit_nxt = bit_r;
    tick_nxt = 1'b0;
    dbg_oe_nxt = 1'b0;
    dbg_o_nxt = 1'b0;
    dbg_rx_nxt = 1'b1;
    if (state_r == RPMSC_ST_RUN) begin
      // debug function only out of reset
      dbg_rx_nxt = dbg_s;
      if (drv_prev_r && !dbg_drive_low_i) begin
        spd_nxt = SW'(SPEEDUP_CYC);
      end else if (spd_r != '0) begin
        spd_nxt = spd_r - SW'(1);
      end
      if (dbg_drive_low_i) begin
        dbg_oe_nxt = 1'b1;
        spd_nxt = '0;
      end else if (spd_nxt != '0) begin
        dbg_oe_nxt = 1'b1;
        dbg_o_nxt = 1'b1;
      end
      if (dbg_bit_sync_i) begin
        bit_nxt = '0;
      end else if (dbg_clk_en) begin
        if (bit_r == BW'(BIT_CYC - 1)) begin
          bit_nxt = '0;
          tick_nxt = 1'b1;
        end else begin
          bit_nxt = bit_r + BW'(1);
        end
      end
    end else begin
      spd_nxt = '0;
      bit_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_prev_r <= 1'b0;
      spd_r <= '0;
      bit_r <= '0;
      tick_r <= 1'b0;
      dbg_oe_r <= 1'b0;
      dbg_o_r <= 1'b0;
      dbg_rx_r <= 1'b1;
    end else if (ce_i) begin
      drv_prev_r <= drv_prev_nxt;
      spd_r <= spd_nxt;
      bit_r <= bit_nxt;
      tick_r <= tick_nxt;
      dbg_oe_r <= dbg_oe_nxt;
      dbg_o_r <= dbg_o_nxt;
      dbg_rx_r <= dbg_rx_nxt;
    end
  end

  assign dbg_pin_o = dbg_o_r;
  assign dbg_pin_oe_o = dbg_oe_r;
  assign dbg_rx_o = dbg_rx_r;
  assign dbg_bit_tick_o = tick_r;

  // ----------------------------------------------------------------
  // Fixed-frequency clock and interrupt pin
  // ----------------------------------------------------------------
  logic ffs_nxt;
  logic half_r, half_nxt;
  logic ffclk_r, ffclk_nxt;
  logic irq_prev_r, irq_prev_nxt;
  logic irq_req_r, irq_req_nxt;
  logic irq_lvl_r, irq_lvl_nxt;
  logic irq_en;

  assign irq_en = ctrl_r[`RPMSC_CTRL_IRQEN];

  always_comb begin
    // gen clock above four times ref
    ffs_nxt = {2'b00, gen_freq_i} > {ref_freq_i, 2'b00};
    half_nxt = half_r;
    ffclk_nxt = 1'b1;
    if (ffs_r) begin
      ffclk_nxt = 1'b0;
      if (ext_ref_tick_i) begin
        half_nxt = !half_r;
        ffclk_nxt = half_r;
      end
    end
    irq_prev_nxt = irq_en ? irq_s : 1'b1;
    irq_req_nxt = irq_en & !irq_s;
    irq_lvl_nxt = irq_en ? irq_s : 1'b1;
    ev_irq = irq_en & irq_prev_r & !irq_s;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ffs_r <= 1'b0;
      half_r <= 1'b0;
      ffclk_r <= 1'b1;
      irq_prev_r <= 1'b1;
      irq_req_r <= 1'b0;
      irq_lvl_r <= 1'b1;
    end else if (ce_i) begin
      ffs_r <= ffs_nxt;
      half_r <= half_nxt;
      ffclk_r <= ffclk_nxt;
      irq_prev_r <= irq_prev_nxt;
      irq_req_r <= irq_req_nxt;
      irq_lvl_r <= irq_lvl_nxt;
    end
  end

  assign fixed_freq_select_o = ffs_r;
  assign ffclk_en_o = ffclk_r;
  assign irq_req_o = irq_req_r;
  assign irq_level_o = irq_lvl_r;

endmodule
